// file: pkg/asc_pkg.sv
// Constants shared by the sixteen-bit asynchronous counter block.
// Assumes byte-wide register port with an eight-bit address.
package asc_pkg;
   // Register addresses
   localparam logic [7:0] ASC_ADDR_FLAG = 8'h0c;
   localparam logic [7:0] ASC_ADDR_CNT_LO = 8'h0e;
   localparam logic [7:0] ASC_ADDR_CNT_HI = 8'h0f;
   localparam logic [7:0] ASC_ADDR_CTL = 8'h10;
   localparam logic [7:0] ASC_ADDR_IRQ_EN = 8'h8c;
   // Control register fields
   localparam int ASC_CTL_RUN = 0;
   localparam int ASC_CTL_CS = 1;
   localparam int ASC_CTL_BYP = 2;
   localparam int ASC_CTL_OSC = 3;
   localparam int ASC_CTL_PS_LO = 4;
   localparam int ASC_CTL_PS_HI = 5;
   localparam int ASC_CTL_SYSCLK = 6;
   localparam logic [7:0] ASC_CTL_WMASK = 8'h3f;
   localparam logic [7:0] ASC_CTL_RESET = 8'h00;
   // Flag and enable registers
   localparam int ASC_FLAG_BIT = 0;
   localparam logic [6:0] ASC_PAD7 = 7'h00;
   localparam logic [7:0] ASC_RD_NONE = 8'h00;
   // Compare unit trigger mode
   localparam logic [3:0] ASC_CMP_SEVT = 4'hb;
   // Counter limits
   localparam logic [15:0] ASC_CNT_MAX = 16'hffff;
   localparam logic [15:0] ASC_CNT_ZERO = 16'h0000;
   localparam logic [2:0] ASC_PRE_ZERO = 3'h0;
   localparam logic [2:0] ASC_PRE_ONE = 3'h1;
   // Instruction clock is one quarter of the system clock
   localparam logic [1:0] ASC_IDIV_LAST = 2'h3;
   localparam logic [1:0] ASC_IDIV_ONE = 2'h1;
   // Synchroniser width: external clock pin and crystal input pin
   localparam int ASC_SYNC_W = 2;
endpackage

// file: src/asc_sync2.sv
// Two-flop synchroniser for pins entering the system clock domain.
// Assumes the inputs are asynchronous levels; output is the second flop.
`timescale 1ns/1ps
`default_nettype none
module asc_sync2
#(
   parameter int WIDTH = 2
)
(
   input wire logic sys_clk_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed
   {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } asc_sync_state_t;

   asc_sync_state_t state_q;
   asc_sync_state_t state_d;

   // Meta flop feeds only the stable flop
   always_comb
   begin
      state_d = state_q;
      for (int i = 0; i < WIDTH; i++)
      begin
         state_d.meta[i] = async_in[i];
         state_d.stable[i] = state_q.meta[i];
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      state_q <= state_d;
   end

   assign sync_out = state_q.stable;
endmodule // asc_sync2
`default_nettype wire

// file: src/asc_counter.sv
// Sixteen-bit timer/counter with prescaler, crystal driver and
// compare-trigger reset, reached over a byte-wide register port.
// Assumes the compare unit and converter sit outside on sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
module asc_counter
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic other_reset_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic ext_clk_in,
   input wire logic crystal_input_pin_in,
   output logic crystal_drive_pin_out,
   input wire logic sleep_in,
   input wire logic sysclk_from_osc_in,
   input wire logic [3:0] compare_mode_field_in,
   input wire logic [15:0] compare_value_in,
   input wire logic adc_enable_in,
   output logic adc_start_out,
   output logic [15:0] count_pair_out,
   output logic timebase_valid_out,
   output logic wake_irq_out
);
   import asc_pkg::*;

   typedef struct packed
   {
      logic [7:0] ctl;
      logic [15:0] cnt;
      logic [2:0] pre;
      logic ovf;
      logic ovf_en;
      logic armed;
      logic prev;
      logic [1:0] idiv;
      logic [7:0] rdata;
      logic drive;
      logic adc;
   } asc_state_t;

   asc_state_t state_q;
   asc_state_t state_d;

   logic [ASC_SYNC_W-1:0] pins_s;
   logic ext_s;
   logic xtal_s;
   logic run;
   logic cs;
   logic byp;
   logic osc_en;
   logic [1:0] ps;
   logic [2:0] ps_mask;
   logic src_lvl;
   logic rise;
   logic fall;
   logic async_mode;
   logic halt;
   logic tick;
   logic pre_hit;
   logic inc;
   logic trig;
   logic wr_lo;
   logic wr_hi;
   logic wr_cnt;
   logic wrap;

   // Pins pass two flops before anything looks at them
   asc_sync2 #(.WIDTH(ASC_SYNC_W)) u_sync
   (
      .sys_clk_in(sys_clk_in),
      .async_in({crystal_input_pin_in, ext_clk_in}),
      .sync_out(pins_s)
   );

   assign ext_s = pins_s[0];
   assign xtal_s = pins_s[1];

   assign run = state_q.ctl[ASC_CTL_RUN];
   assign cs = state_q.ctl[ASC_CTL_CS];
   assign byp = state_q.ctl[ASC_CTL_BYP];
   assign osc_en = state_q.ctl[ASC_CTL_OSC];
   assign ps = state_q.ctl[ASC_CTL_PS_HI:ASC_CTL_PS_LO];

   // Oscillator enable steers the count input to the crystal pin
   assign src_lvl = osc_en ? xtal_s : ext_s;
   assign rise = src_lvl & ~state_q.prev;
   assign fall = ~src_lvl & state_q.prev;

   // Bypass only matters in counter mode
   assign async_mode = cs & byp;

   // Sleep holds the count except with cs and byp both set; the
   // unsynchronised counter keeps going so it can wake the core
   assign halt = sleep_in & ~async_mode;

   // Quarter-rate instruction tick or armed rising pin edge
   assign tick = cs ? (rise & state_q.armed) : (state_q.idiv == ASC_IDIV_LAST);

   // Mask of prescaler bits that must be ones: 000,001,011,111
   assign ps_mask = {&ps, ps[1], |ps};
   assign pre_hit = (state_q.pre & ps_mask) == ps_mask;
   assign inc = run & tick & pre_hit & ~halt;

   // Compare match clears the count, making compare value the period
   assign trig = run & ~async_mode & (compare_mode_field_in == ASC_CMP_SEVT)
      & (state_q.cnt == compare_value_in);

   assign wr_lo = wr_in & (addr_in == ASC_ADDR_CNT_LO);
   assign wr_hi = wr_in & (addr_in == ASC_ADDR_CNT_HI);
   assign wr_cnt = wr_lo | wr_hi;
   assign wrap = inc & (state_q.cnt == ASC_CNT_MAX) & ~wr_cnt & ~trig;

   always_comb
   begin
      state_d = state_q;
      state_d.adc = 1'b0;
      state_d.rdata = ASC_RD_NONE;
      state_d.prev = src_lvl;
      state_d.idiv = 2'(state_q.idiv + ASC_IDIV_ONE);
      state_d.drive = osc_en & ~xtal_s;

      // Counting waits for a falling edge after each enable
      if (!run || !cs)
      begin
         state_d.armed = 1'b0;
      end
      else if (fall)
      begin
         state_d.armed = 1'b1;
      end

      // Prescaler keeps running through sleep
      if (run && tick)
      begin
         state_d.pre = pre_hit ? ASC_PRE_ZERO : 3'(state_q.pre + ASC_PRE_ONE);
      end

      // Write beats trigger, trigger beats increment
      if (wr_lo)
      begin
         state_d.cnt[7:0] = wdata_in;
      end
      else if (wr_hi)
      begin
         state_d.cnt[15:8] = wdata_in;
      end
      else if (trig)
      begin
         state_d.cnt = ASC_CNT_ZERO;
      end
      else if (inc)
      begin
         state_d.cnt = 16'(state_q.cnt + 16'h0001);
      end
      if (wr_cnt)
      begin
         state_d.pre = ASC_PRE_ZERO;
      end

      if (trig && adc_enable_in)
      begin
         state_d.adc = 1'b1;
      end

      if (wr_in && addr_in == ASC_ADDR_CTL)
      begin
         state_d.ctl = wdata_in & ASC_CTL_WMASK;
      end
      if (wr_in && addr_in == ASC_ADDR_IRQ_EN)
      begin
         state_d.ovf_en = wdata_in[ASC_FLAG_BIT];
      end
      if (wr_in && addr_in == ASC_ADDR_FLAG)
      begin
         state_d.ovf = wdata_in[ASC_FLAG_BIT];
      end
      // A wrap in the clearing cycle still lands
      if (wrap)
      begin
         state_d.ovf = 1'b1;
      end

      // Reads come from one clocked copy, so a byte is never torn
      if (rd_in)
      begin
         if (addr_in == ASC_ADDR_CNT_LO)
         begin
            state_d.rdata = state_q.cnt[7:0];
         end
         else if (addr_in == ASC_ADDR_CNT_HI)
         begin
            state_d.rdata = state_q.cnt[15:8];
         end
         else if (addr_in == ASC_ADDR_CTL)
         begin
            state_d.rdata = state_q.ctl;
            state_d.rdata[ASC_CTL_SYSCLK] = sysclk_from_osc_in;
         end
         else if (addr_in == ASC_ADDR_FLAG)
         begin
            state_d.rdata = {ASC_PAD7, state_q.ovf};
         end
         else if (addr_in == ASC_ADDR_IRQ_EN)
         begin
            state_d.rdata = {ASC_PAD7, state_q.ovf_en};
         end
         else
         begin
            state_d.rdata = ASC_RD_NONE;
         end
      end

      // Count bytes are left alone by every reset
      if (rst_in || other_reset_in)
      begin
         state_d.pre = ASC_PRE_ZERO;
         state_d.armed = 1'b0;
         state_d.ovf = 1'b0;
         state_d.ovf_en = 1'b0;
         state_d.adc = 1'b0;
         state_d.rdata = ASC_RD_NONE;
         state_d.drive = 1'b0;
         state_d.cnt = state_q.cnt;
      end
      if (rst_in)
      begin
         state_d.ctl = ASC_CTL_RESET;
         state_d.idiv = ASC_PRE_ZERO[1:0];
         state_d.prev = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      state_q <= state_d;
   end

   assign rdata_out = state_q.rdata;
   assign crystal_drive_pin_out = state_q.drive;
   assign adc_start_out = state_q.adc;
   assign count_pair_out = state_q.cnt;
   // Capture and compare must ignore the count while unsynchronised
   assign timebase_valid_out = ~async_mode;
   assign wake_irq_out = state_q.ovf & state_q.ovf_en;

   sequence s_quiet3;
      !inc [*3];
   endsequence

   sequence s_wrap_hit;
      inc && state_q.cnt == ASC_CNT_MAX && !wr_cnt && !trig && !rst_in
         && !other_reset_in;
   endsequence

   AST_WRAP_FLAG: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      s_wrap_hit |=> state_q.cnt == ASC_CNT_ZERO && state_q.ovf)
      else $error("wrap did not clear count and set flag");

   AST_WRITE_WINS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      wr_lo && trig |=> state_q.cnt[7:0] == $past(wdata_in))
      else $error("trigger overrode a count write");

   AST_TRIG_CLEAR: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      trig && !wr_cnt && !other_reset_in |=> state_q.cnt == ASC_CNT_ZERO)
      else $error("trigger did not clear count");

   AST_TRIG_NO_FLAG: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      trig && !state_q.ovf && !(wr_in && addr_in == ASC_ADDR_FLAG) |=> !state_q.ovf)
      else $error("trigger set overflow flag");

   AST_ASYNC_NO_TRIG: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      cs && byp |-> !trig && !timebase_valid_out)
      else $error("unsynchronised count used as timebase");

   AST_PRE_CLEAR: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      wr_cnt |=> state_q.pre == ASC_PRE_ZERO)
      else $error("count write left prescaler set");

   AST_POR_CTL: assert property (@(posedge sys_clk_in)
      rst_in |=> state_q.ctl == ASC_CTL_RESET && !run)
      else $error("power-on reset left control set");

   AST_SOFT_KEEP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      other_reset_in && !wr_in |=> $stable(state_q.cnt) && $stable(state_q.ctl))
      else $error("soft reset disturbed count or control");

   AST_SLEEP_HOLD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      sleep_in && !(cs && byp) |-> !inc)
      else $error("synchronised count moved in sleep");

   AST_ARM_FIRST: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      cs && !state_q.armed |-> !inc)
      else $error("counted before a falling edge");

   AST_PRESCALE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      inc |=> state_q.pre == ASC_PRE_ZERO)
      else $error("prescaler did not restart after a count");

   AST_TIMER_RATE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      inc && !cs |=> s_quiet3)
      else $error("timer mode faster than quarter clock");

   AST_READ_LO: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      rd_in && addr_in == ASC_ADDR_CNT_LO && !other_reset_in
         |=> rdata_out == $past(state_q.cnt[7:0]))
      else $error("low byte read mismatched count");
endmodule // asc_counter
`default_nettype wire

// file: dv/asc_xtal_src.sv
// External count clock and watch crystal beside the counter's pins.
// Assumes the bench starts and stops the clock between measurements.
`timescale 1ns/1ps
`default_nettype none
module asc_xtal_src
#(
   parameter int STARTUP_NS = 2000
)
(
   input wire logic run_in,
   input wire logic idle_in,
   input wire logic xtal_on_in,
   output logic ext_clk_out,
   output logic xtal_out
);
   int up_ns;
   initial
   begin
      ext_clk_out = 1'b0;
      xtal_out = 1'b0;
      up_ns = 0;
      // Odd offset keeps pin edges away from the system clock edges
      #7;
      forever
      begin
         // Clock stands at the idle level outside frames
         ext_clk_out = run_in ? ~ext_clk_out : idle_in;
         if (!xtal_on_in)
         begin
            up_ns = 0;
            xtal_out = 1'b0;
         end
         else if (up_ns < STARTUP_NS)
            up_ns = up_ns + 100;
         else
            xtal_out = ~xtal_out;
         #100;
      end
   end
endmodule // asc_xtal_src
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the sixteen-bit counter.
// Assumes asc_pkg and the partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import asc_pkg::*;
   logic sys_clk_in = 0, rst_in = 1, other_reset_in = 0;
   logic wr_in = 0, rd_in = 0, sleep_in = 0, sysclk_sel = 0, adc_en = 0;
   logic [7:0] addr_in = 0, wdata_in = 0, rdata_out;
   logic [3:0] cmp_mode = 0;
   logic [15:0] cmp_val = 0, cnt;
   logic ext_clk, xtal, drive, adc_start, tb_valid, wake;
   logic run_src = 0, idle_src = 0, xtal_on = 0, rd_seen = 0;
   logic [15:0] exp_q[$];
   int err_total = 0, compares = 0, cyc = 0, adc_cnt = 0;
   asc_counter dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .other_reset_in(other_reset_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .ext_clk_in(ext_clk),
      .crystal_input_pin_in(xtal), .crystal_drive_pin_out(drive),
      .sleep_in(sleep_in), .sysclk_from_osc_in(sysclk_sel),
      .compare_mode_field_in(cmp_mode), .compare_value_in(cmp_val),
      .adc_enable_in(adc_en), .adc_start_out(adc_start),
      .count_pair_out(cnt), .timebase_valid_out(tb_valid),
      .wake_irq_out(wake));
   asc_xtal_src src (.run_in(run_src), .idle_in(idle_src),
      .xtal_on_in(xtal_on), .ext_clk_out(ext_clk), .xtal_out(xtal));
   always #12.5 sys_clk_in = ~sys_clk_in;
   task check(input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e)
      begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Read data stand only in the cycle after the strobe
   always @(posedge sys_clk_in)
   begin
      cyc <= cyc + 1;
      if (adc_start === 1'b1)
         adc_cnt <= adc_cnt + 1;
      if (rd_seen)
         check({8'h00, rdata_out}, exp_q.pop_front());
      rd_seen <= rd_in;
   end
   task cy(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      cy(1);
      wr_in <= 1'b0;
      cy(1);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      addr_in <= a;
      rd_in <= 1'b1;
      exp_q.push_back({8'h00, e});
      cy(1);
      rd_in <= 1'b0;
      cy(2);
   endtask
   // Count is written only while stopped
   task wcnt(input logic [15:0] v);
      wr(ASC_ADDR_CNT_HI, v[15:8]);
      wr(ASC_ADDR_CNT_LO, v[7:0]);
   endtask
   task meas(input int n, output logic [15:0] d);
      logic [15:0] c0;
      c0 = cnt;
      cy(n);
      d = cnt - c0;
   endtask
   task hit(input logic [15:0] v);
      for (int i = 0; i < 300 && cnt !== v; i++)
         cy(1);
   endtask
   function automatic logic [7:0] cr(input logic [7:0] x);
      return x | {1'b0, sysclk_sel, 6'h00};
   endfunction
   task print_verdict;
      $display("counts: %0d compares, %0d errors", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #2000000;
      err_total++;
      print_verdict;
   end
   initial
   begin
      logic [15:0] v, d;
      int t0, a0;
      v = 16'($urandom(32'h88b2));
      sysclk_sel <= 1'($urandom);
      cy(6);
      rst_in <= 1'b0;
      cy(1);
      rd(ASC_ADDR_CTL, cr(ASC_CTL_RESET));
      rd(ASC_ADDR_FLAG, 8'h00);
      rd(8'h11, ASC_RD_NONE);
      wr(ASC_ADDR_CTL, 8'hff);
      rd(ASC_ADDR_CTL, cr(ASC_CTL_WMASK));
      check({15'h0, drive}, 16'h0001);
      wr(ASC_ADDR_CTL, 8'h00);
      cy(2);
      check({15'h0, drive}, 16'h0000);
      $display("test regs done");
      v = 16'($urandom);
      wcnt(v);
      wr(ASC_ADDR_CTL, 8'h30);
      other_reset_in <= 1'b1;
      cy(2);
      other_reset_in <= 1'b0;
      rd(ASC_ADDR_CTL, cr(8'h30));
      rd(ASC_ADDR_CNT_HI, v[15:8]);
      rst_in <= 1'b1;
      cy(2);
      rst_in <= 1'b0;
      rd(ASC_ADDR_CTL, cr(ASC_CTL_RESET));
      rd(ASC_ADDR_CNT_LO, v[7:0]);
      $display("test resets done");
      // Window is a whole number of prescaled periods, so the phase drops out
      for (int p = 0; p < 4; p++)
      begin
         wcnt(ASC_CNT_ZERO);
         wr(ASC_ADDR_CTL, {2'b00, p[1:0], 4'h1});
         cy(8);
         meas(16 << p, d);
         check(d, 16'h0004);
         wr(ASC_ADDR_CTL, 8'h00);
      end
      wcnt(16'h1200);
      wr(ASC_ADDR_CTL, 8'h31);
      // Long enough that an uncleared prescaler would reach a count
      for (int i = 0; i < 20; i++)
         wr(ASC_ADDR_CNT_HI, 8'h12);
      wr(ASC_ADDR_CTL, 8'h00);
      rd(ASC_ADDR_CNT_LO, 8'h00);
      $display("test prescale done");
      wcnt(ASC_CNT_MAX);
      wr(ASC_ADDR_IRQ_EN, 8'h01);
      wr(ASC_ADDR_CTL, 8'h01);
      hit(ASC_CNT_ZERO);
      check(cnt, ASC_CNT_ZERO);
      check({15'h0, wake}, 16'h0001);
      wr(ASC_ADDR_CTL, 8'h00);
      rd(ASC_ADDR_FLAG, 8'h01);
      wr(ASC_ADDR_IRQ_EN, 8'h00);
      check({15'h0, wake}, 16'h0000);
      wr(ASC_ADDR_FLAG, 8'h00);
      rd(ASC_ADDR_FLAG, 8'h00);
      $display("test wrap done");
      v = 16'h0008 + 16'($urandom_range(0, 15));
      wcnt(ASC_CNT_ZERO);
      cmp_val <= v;
      cmp_mode <= ASC_CMP_SEVT;
      for (int e = 1; e >= 0; e--)
      begin
         adc_en <= e[0];
         wr(ASC_ADDR_CTL, 8'h01);
         hit(v);
         t0 = cyc;
         a0 = adc_cnt;
         cy(1);
         hit(v);
         check(16'(cyc - t0), 16'(4 * v));
         check(16'(adc_cnt - a0), 16'(e));
         wr(ASC_ADDR_CTL, 8'h00);
      end
      // Compare value zero holds the clear on, so the write meets it
      cmp_val <= ASC_CNT_ZERO;
      wcnt(ASC_CNT_ZERO);
      wr(ASC_ADDR_CTL, 8'h31);
      wr(ASC_ADDR_CNT_LO, 8'h5a);
      rd(ASC_ADDR_CNT_LO, 8'h5a);
      wr(ASC_ADDR_CTL, 8'h00);
      wcnt(ASC_CNT_ZERO);
      cmp_val <= v;
      rd(ASC_ADDR_FLAG, 8'h00);
      cmp_mode <= 4'ha;
      wr(ASC_ADDR_CTL, 8'h01);
      cy(4 * v + 16);
      check({15'h0, cnt > v}, 16'h0001);
      wr(ASC_ADDR_CTL, 8'h00);
      $display("test trigger done");
      run_src <= 1'b1;
      wr(ASC_ADDR_CTL, 8'h03);
      cy(16);
      meas(64, d);
      check(d, 16'h0008);
      sleep_in <= 1'b1;
      cy(8);
      meas(64, d);
      check(d, 16'h0000);
      wr(ASC_ADDR_CTL, 8'h07);
      cy(16);
      meas(64, d);
      check(d, 16'h0008);
      check({15'h0, tb_valid}, 16'h0000);
      sleep_in <= 1'b0;
      wr(ASC_ADDR_CTL, 8'h00);
      run_src <= 1'b0;
      cy(16);
      wr(ASC_ADDR_CTL, 8'h03);
      v = cnt;
      idle_src <= 1'b1;
      cy(16);
      check(cnt - v, 16'h0000);
      idle_src <= 1'b0;
      cy(16);
      idle_src <= 1'b1;
      cy(16);
      check(cnt - v, 16'h0001);
      $display("test pin done");
      wr(ASC_ADDR_CTL, 8'h0b);
      xtal_on <= 1'b1;
      // Start-up is not flagged, so wait past it
      cy(100);
      meas(64, d);
      check(d, 16'h0008);
      // Watch-crystal use: wrap in sleep, then preload the high msb only
      wr(ASC_ADDR_CTL, 8'h0a);
      wcnt(16'hfffc);
      wr(ASC_ADDR_IRQ_EN, 8'h01);
      sleep_in <= 1'b1;
      wr(ASC_ADDR_CTL, 8'h0f);
      hit(ASC_CNT_ZERO);
      check({15'h0, wake}, 16'h0001);
      wr(ASC_ADDR_CTL, 8'h0e);
      sleep_in <= 1'b0;
      wr(ASC_ADDR_CNT_HI, 8'h80);
      rd(ASC_ADDR_CNT_HI, 8'h80);
      rd(ASC_ADDR_CNT_LO, 8'h00);
      rd(ASC_ADDR_CNT_HI, 8'h80);
      rd(ASC_ADDR_FLAG, 8'h01);
      wr(ASC_ADDR_FLAG, 8'h00);
      wr(ASC_ADDR_IRQ_EN, 8'h00);
      xtal_on <= 1'b0;
      wr(ASC_ADDR_CTL, 8'h00);
      $display("test crystal done");
      print_verdict;
   end
endmodule // tb_top
`default_nettype wire
